//--- ddrba_map.svh
`ifndef DDRBA_MAP_SVH
`define DDRBA_MAP_SVH
// lane geometry
`define DDRBA_LANES       16
`define DDRBA_DESER       8
`define DDRBA_WORD_W      128
`define DDRBA_TAP_W       6
`define DDRBA_TAP_MAX     6'h3f
`define DDRBA_TAP_RST     6'h00
// word alignment pattern, first bit in the msb
`define DDRBA_WORD_PAT    8'hbf
// settle after a tap step, in divided-clock cycles
`define DDRBA_SETTLE      4'h4
// wait after a slip pulse before the word is trusted
`define DDRBA_SLIP_WAIT   4'h2
// slips to try before giving up, one per bit position
`define DDRBA_SLIP_MAX    4'h8
`endif

//--- ddrba_pkg.sv
package ddrba_pkg;
    // per-lane training states
    typedef enum logic [3:0] {
        DDRBA_ST_FIRST   = 4'h0,
        DDRBA_ST_WAIT    = 4'h1,
        DDRBA_ST_FIND1   = 4'h3,
        DDRBA_ST_FIND2   = 4'h2,
        DDRBA_ST_CENTER  = 4'h6,
        DDRBA_ST_WCHECK  = 4'h7,
        DDRBA_ST_WSLIP   = 4'h5,
        DDRBA_ST_DONE    = 4'h4,
        DDRBA_ST_FAIL    = 4'hc
    } ddrba_state_e;
    typedef logic [7:0] ddrba_byte_t;
endpackage : ddrba_pkg

//--- ddrba_lane.sv
`timescale 1ns/10ps
`default_nettype none
`include "ddrba_map.svh"
// one lane: bit centring then word alignment
module ddrba_lane
    import ddrba_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    // deserializer word of this lane
    input  wire logic [7:0] deser_i,
    // tap delay and slip controls
    output logic            tap_inc_o,
    output logic            tap_dec_o,
    output logic            slip_o,
    output logic [5:0]      tap_o,
    output logic [5:0]      eye_o,
    // status
    output logic            done_o,
    output logic            fail_o
);
    ddrba_state_e state;
    ddrba_state_e ret;
    logic [3:0]   wait_cnt;
    logic [5:0]   tap;
    logic [5:0]   cnt;
    logic [3:0]   slips;
    logic [7:0]   ref_w;

    // classify the sampled word: all ones, all zeros or unstable
    wire  stable     = (deser_i == 8'hff) || (deser_i == 8'h00);
    wire  edge_seen  = !stable || (deser_i != ref_w);
    wire  at_top     = (tap == `DDRBA_TAP_MAX);
    wire  word_match = (deser_i == `DDRBA_WORD_PAT);
    wire  [5:0] half = {1'b0, cnt[5:1]};

    // one tap step per lane, every lane on its own counter
    always_ff @(posedge clk_i)
    begin
        tap_inc_o <= 1'b0;
        tap_dec_o <= 1'b0;
        slip_o    <= 1'b0;
        if (!nrst_i)
        begin
            state    <= DDRBA_ST_FIRST;
            ret      <= DDRBA_ST_FIRST;
            wait_cnt <= 4'h0;
            tap      <= `DDRBA_TAP_RST;
            cnt      <= 6'h00;
            slips    <= 4'h0;
            ref_w    <= 8'h00;
            eye_o    <= 6'h00;
        end
        else
        begin
            unique case (state)
                // unstable start steps on until a clean level
                DDRBA_ST_FIRST:
                    if (stable)
                    begin
                        ref_w <= deser_i;
                        state <= DDRBA_ST_FIND1;
                    end
                    else if (at_top)
                        state <= DDRBA_ST_FAIL;
                    else
                    begin
                        tap       <= tap + 6'h01;
                        tap_inc_o <= 1'b1;
                        wait_cnt  <= `DDRBA_SETTLE;
                        ret       <= DDRBA_ST_FIRST;
                        state     <= DDRBA_ST_WAIT;
                    end
                DDRBA_ST_WAIT:
                    if (wait_cnt == 4'h1)
                        state <= ret;
                    else
                        wait_cnt <= wait_cnt - 4'h1;
                // walk to the first transition of the eye
                DDRBA_ST_FIND1:
                    if (edge_seen && stable)
                    begin
                        ref_w <= deser_i;
                        cnt   <= 6'h00;
                        state <= DDRBA_ST_FIND2;
                    end
                    else if (at_top)
                        state <= DDRBA_ST_FAIL;
                    else
                    begin
                        tap       <= tap + 6'h01;
                        tap_inc_o <= 1'b1;
                        wait_cnt  <= `DDRBA_SETTLE;
                        ret       <= DDRBA_ST_FIND1;
                        state     <= DDRBA_ST_WAIT;
                    end
                // count taps across the eye to the next transition
                DDRBA_ST_FIND2:
                    if (edge_seen && cnt != 6'h00)
                    begin
                        eye_o <= cnt;
                        state <= DDRBA_ST_CENTER;
                    end
                    else if (at_top)
                        state <= DDRBA_ST_FAIL;
                    else
                    begin
                        tap       <= tap + 6'h01;
                        cnt       <= cnt + 6'h01;
                        tap_inc_o <= 1'b1;
                        wait_cnt  <= `DDRBA_SETTLE;
                        ret       <= DDRBA_ST_FIND2;
                        state     <= DDRBA_ST_WAIT;
                    end
                // one-shot pull back by half the eye width
                DDRBA_ST_CENTER:
                begin
                    tap      <= tap - half;
                    wait_cnt <= `DDRBA_SETTLE;
                    ret      <= DDRBA_ST_WCHECK;
                    state    <= DDRBA_ST_WAIT;
                    tap_dec_o <= (half != 6'h00);
                end
                DDRBA_ST_WCHECK:
                    if (word_match)
                        state <= DDRBA_ST_DONE;
                    else if (slips == `DDRBA_SLIP_MAX)
                        state <= DDRBA_ST_FAIL;
                    else
                        state <= DDRBA_ST_WSLIP;
                // one-cycle slip then three cycles before checking
                DDRBA_ST_WSLIP:
                begin
                    slip_o   <= 1'b1;
                    slips    <= slips + 4'h1;
                    wait_cnt <= `DDRBA_SLIP_WAIT + 4'h1;
                    ret      <= DDRBA_ST_WCHECK;
                    state    <= DDRBA_ST_WAIT;
                end
                DDRBA_ST_DONE:
                    state <= DDRBA_ST_DONE;
                default:
                    state <= DDRBA_ST_FAIL;
            endcase
        end
    end

    assign tap_o  = tap;
    assign done_o = (state == DDRBA_ST_DONE);
    assign fail_o = (state == DDRBA_ST_FAIL);
endmodule : ddrba_lane
`default_nettype wire

//--- ddrba_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "ddrba_map.svh"
module ddrba_top
    import ddrba_pkg::*;
(
    // divided clock domain and fabric reset
    input  wire logic          clk_i,
    input  wire logic          nrst_i,
    // deserializer outputs, lane n in bits 8n+7..8n
    input  wire logic [127:0]  deser_i,
    // per-lane tap delay and slip controls
    output logic      [15:0]   tap_inc_o,
    output logic      [15:0]   tap_dec_o,
    output logic      [15:0]   slip_o,
    output logic      [95:0]   tap_o,
    output logic      [95:0]   eye_o,
    // user data and status
    output logic      [127:0]  data_o,
    output logic               data_valid_o,
    output logic      [15:0]   lane_done_o,
    output logic      [15:0]   lane_fail_o
);
    // the deserializer word is already on the divided clock, no sync
    logic [127:0] word_q;

    // one trainer per lane so skew never eats the window
    genvar g;
    generate
        for (g = 0; g < `DDRBA_LANES; g = g + 1)
        begin : g_lane
            ddrba_lane u_lane (
                .clk_i     (clk_i),
                .nrst_i    (nrst_i),
                .deser_i   (deser_i[8*g +: 8]),
                .tap_inc_o (tap_inc_o[g]),
                .tap_dec_o (tap_dec_o[g]),
                .slip_o    (slip_o[g]),
                .tap_o     (tap_o[6*g +: 6]),
                .eye_o     (eye_o[6*g +: 6]),
                .done_o    (lane_done_o[g]),
                .fail_o    (lane_fail_o[g])
            );
        end
    endgenerate

    wire all_done = &lane_done_o;

    // register the parallel word; valid only once all lanes lock
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            word_q       <= 128'h0;
            data_valid_o <= 1'b0;
        end
        else
        begin
            word_q       <= deser_i;
            data_valid_o <= all_done;
        end
    end

    assign data_o = word_q;
endmodule : ddrba_top
`default_nettype wire

//--- ddrba_properties.sv
`timescale 1ns/10ps
`default_nettype none
// watches the top ports only
module ddrba_properties (
    // clock and reset
    input wire logic         clk_i,
    input wire logic         nrst_i,
    // lane words and controls
    input wire logic [127:0] deser_i,
    input wire logic [15:0]  tap_inc_o,
    input wire logic [15:0]  tap_dec_o,
    input wire logic [15:0]  slip_o,
    input wire logic [95:0]  tap_o,
    input wire logic [95:0]  eye_o,
    // data and status
    input wire logic [127:0] data_o,
    input wire logic         data_valid_o,
    input wire logic [15:0]  lane_done_o,
    input wire logic [15:0]  lane_fail_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    // past guard: first edge after reset still sees old state
    property p_slip_gap;
        $past(nrst_i) |-> (slip_o & ($past(slip_o) | $past(slip_o, 2))) == 0;
    endproperty
    a_slip_gap: assert property (p_slip_gap)
        else $error("slip pulses too close");
    property p_inc_step;
        tap_inc_o[0] |-> tap_o[5:0] == $past(tap_o[5:0]) + 6'h1;
    endproperty
    a_inc_step: assert property (p_inc_step)
        else $error("tap did not step with inc");
    property p_inc_settle;
        tap_inc_o[0] |=> !tap_inc_o[0] [*3];
    endproperty
    a_inc_settle: assert property (p_inc_settle)
        else $error("tap stepped before settling");
    property p_dec_half;
        tap_dec_o[0] |-> tap_o[5:0] == $past(tap_o[5:0]) - (eye_o[5:0] >> 1);
    endproperty
    a_dec_half: assert property (p_dec_half)
        else $error("centre not half the eye");
    property p_quiet_done;
        (lane_done_o & (tap_inc_o | tap_dec_o | slip_o)) == 16'h0;
    endproperty
    a_quiet_done: assert property (p_quiet_done)
        else $error("done lane still moving");
    property p_valid;
        $past(nrst_i) |-> data_valid_o == &$past(lane_done_o);
    endproperty
    a_valid: assert property (p_valid)
        else $error("valid not following all done");
    property p_data;
        $past(nrst_i) |-> data_o == $past(deser_i);
    endproperty
    a_data: assert property (p_data)
        else $error("data not one cycle after word");
    property p_sticky;
        $past(nrst_i) |-> (lane_done_o & $past(lane_done_o)) == $past(lane_done_o);
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("done dropped");
    property p_done_pat;
        $past(nrst_i) && $rose(lane_done_o[3]) |-> $past(deser_i[31:24]) == 8'hbf;
    endproperty
    a_done_pat: assert property (p_done_pat)
        else $error("done without pattern");
    property p_excl;
        (lane_done_o & lane_fail_o) == 16'h0;
    endproperty
    a_excl: assert property (p_excl)
        else $error("lane both done and failed");
endmodule : ddrba_properties
`default_nettype wire

//--- ddrba_tx_model.sv
`timescale 1ns/10ps
`default_nettype none
// far transmitter plus delay lines, behavioural
module ddrba_tx_model (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         nrst_i,
    // receiver controls
    input  wire logic [15:0]  tap_inc_i,
    input  wire logic [15:0]  tap_dec_i,
    input  wire logic [95:0]  tap_i,
    input  wire logic [15:0]  slip_i,
    // user side
    input  wire logic [127:0] user_i,
    input  wire logic         send_i,
    input  wire logic         stuck_i,
    output logic      [127:0] deser_o
);
    logic [5:0]  tap [16];
    logic [2:0]  rot [16];
    logic [15:0] wmode;
    logic [15:0] s1;
    logic [15:0] s2;
    int          p;
    // slip lands two cycles late, clock path never moves
    always_ff @(posedge clk_i)
    begin
        s1 <= nrst_i ? slip_i : 16'h0;
        s2 <= nrst_i ? s1 : 16'h0;
        for (int n = 0; n < 16; n++)
        begin
            if (!nrst_i)
            begin
                tap[n] <= 6'h00;
                rot[n] <= 3'(n);
                wmode[n] <= 1'b0;
            end
            else
            begin
                if (tap_inc_i[n])
                    tap[n] <= tap[n] + 6'h1;
                if (tap_dec_i[n])
                    tap[n] <= tap_i[6*n+:6];
                if (tap_dec_i[n])
                    wmode[n] <= 1'b1;
                if (s2[n])
                    rot[n] <= rot[n] + 3'h1;
            end
        end
    end
    // lane n skewed by 5n taps, bit period 14 taps
    always_comb
    begin
        for (int n = 0; n < 16; n++)
        begin
            p = int'(tap[n]) + n * 5;
            if (send_i)
                deser_o[8*n+:8] = user_i[8*n+:8];
            else if (wmode[n])
                deser_o[8*n+:8] = 8'({8'hbf, 8'hbf} >> (8 - rot[n]));
            else if (stuck_i && n == 0)
                deser_o[8*n+:8] = 8'h00;
            else if (p % 14 == 0)
                deser_o[8*n+:8] = 8'h5a;
            else
                deser_o[8*n+:8] = (p / 14) % 2 ? 8'hff : 8'h00;
        end
    end
endmodule : ddrba_tx_model
`default_nettype wire

//--- ddrba_top_bench.sv
`timescale 1ns/10ps
`default_nettype none
// trains all lanes through the model, then random data
module ddrba_top_bench;
    logic         clk_i = 1'b0;
    logic         nrst_i = 1'b0;
    logic         stuck = 1'b0;
    logic [127:0] user = '0;
    logic [127:0] deser;
    logic [127:0] prev;
    logic [15:0]  inc, dec, slip, done, fail;
    logic [95:0]  tap, eye;
    logic [127:0] data;
    logic         valid;
    logic [31:0]  lfsr = 32'h1eb7;
    int           fails = 0;
    int           tests_run = 0;
    int           k;
    always #5 clk_i = ~clk_i;
    ddrba_tx_model u_tx (.clk_i(clk_i), .nrst_i(nrst_i), .tap_inc_i(inc),
        .tap_dec_i(dec), .tap_i(tap), .slip_i(slip), .user_i(user),
        .send_i(valid), .stuck_i(stuck), .deser_o(deser));
    ddrba_top u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .deser_i(deser),
        .tap_inc_o(inc), .tap_dec_o(dec), .slip_o(slip), .tap_o(tap),
        .eye_o(eye), .data_o(data), .data_valid_o(valid),
        .lane_done_o(done), .lane_fail_o(fail));
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : next_rand
    // centred if sample sits 5..9 taps into the 14 tap bit
    function automatic logic mid_ok(input int n, input logic [5:0] t);
        return ((int'(t) + 5 * n) % 14) inside {[5:9]};
    endfunction : mid_ok
    task check(input logic [127:0] seen, input logic [127:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task conclude;
        $display("tests_run=%0d fails=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude
    // sync reset for 16 cycles, optional dead lane 0
    task do_reset(input logic s);
        nrst_i = 1'b0;
        stuck = s;
        repeat (16) @(posedge clk_i);
        #1 nrst_i = 1'b1;
        check({tap, done, fail, valid}, '0);
    endtask : do_reset
    // bounded wait until every lane settled
    task settle;
        for (k = 0; k < 4000 && (done | fail) !== 16'hffff; k++)
            @(posedge clk_i) #1;
    endtask : settle
    initial
    begin
        #300000;
        fails++;
        conclude();
    end
    initial
    begin
        do_reset(1'b0);
        settle();
        @(posedge clk_i) #1;
        check({done, fail, valid}, {16'hffff, 16'h0, 1'b1});
        for (int n = 0; n < 16; n++)
        begin
            check(mid_ok(n, tap[6*n+:6]), 1'b1);
            check((eye[6*n+:6] inside {[13:15]}), 1'b1);
        end
        prev = deser;
        repeat (200)
        begin
            @(posedge clk_i) #1;
            check(data, prev);
            lfsr = next_rand(lfsr);
            user = {user[95:0], lfsr};
            #1 prev = deser;
        end
        do_reset(1'b1);
        settle();
        check({done, fail, valid}, {16'hfffe, 16'h1, 1'b0});
        conclude();
    end
endmodule : ddrba_top_bench
bind ddrba_top ddrba_properties u_prop (.clk_i(clk_i), .nrst_i(nrst_i),
    .deser_i(deser_i), .tap_inc_o(tap_inc_o), .tap_dec_o(tap_dec_o),
    .slip_o(slip_o), .tap_o(tap_o), .eye_o(eye_o), .data_o(data_o),
    .data_valid_o(data_valid_o), .lane_done_o(lane_done_o),
    .lane_fail_o(lane_fail_o));
`default_nettype wire
